// ==== src/sfr_consts.svh ====
// constants of the synchronous flash read interface
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH
`define SFR_DW 16
`define SFR_ROW_W 12
`define SFR_COL_W 8
`define SFR_BANKS 4
`define SFR_BLOCKS 16
`define SFR_WBUF_DEPTH 8
`define SFR_MR_BL_LSB 0
`define SFR_MR_BL_MSB 2
`define SFR_MR_BT_BIT 3
`define SFR_MR_LAT_LSB 4
`define SFR_MR_LAT_MSB 6
`define SFR_SEQ_SEL_BIT 10
`define SFR_BLK_ROW_MSB 11
`define SFR_BLK_ROW_LSB 10
`define SFR_BL_CODE_FULL 3'h7
`define SFR_BL_RST 3'h0
`define SFR_BT_RST 1'b0
`define SFR_LAT_RST 2'h3
`endif

// ==== src/sfr_pkg.sv ====
// types of the synchronous flash read interface
`include "sfr_consts.svh"
package sfr_pkg;
  typedef enum logic [2:0] {
    SFR_CMD_NOP, SFR_CMD_LMR, SFR_CMD_ACT, SFR_CMD_RD, SFR_CMD_WR, SFR_CMD_BST, SFR_CMD_PRE
  } sfr_cmd_t;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [`SFR_ROW_W-1:0] addr;
  } sfr_pins_t;
  typedef struct packed {
    logic rd;
    logic [1:0] bank;
    logic [`SFR_ROW_W-1:0] row;
    logic [`SFR_COL_W-1:0] col;
  } sfr_arr_req_t;
  typedef struct packed {
    logic sw_seq;
    logic [3:0] blk;
    logic [1:0] bank;
    logic [`SFR_ROW_W-1:0] row;
    logic [`SFR_COL_W-1:0] col;
    logic [`SFR_DW-1:0] data;
  } sfr_pgm_pkt_t;
  typedef struct packed {
    logic [2:0] bl;
    logic bt;
    logic [1:0] lat;
    logic [`SFR_BANKS-1:0] open;
    logic [`SFR_BANKS-1:0][`SFR_ROW_W-1:0] row;
    logic rd_act;
    logic [1:0] rd_bank;
    logic [`SFR_COL_W-1:0] rd_start;
    logic [`SFR_COL_W-1:0] rd_cnt;
    sfr_arr_req_t arr;
    logic [2:0] vp;
    logic [`SFR_DW-1:0] d1;
    logic [`SFR_DW-1:0] d2;
    logic [`SFR_DW-1:0] dq;
    logic dq_oe_n;
    logic wact;
    logic wdrain;
    logic wseq;
    logic [1:0] wbank;
    logic [`SFR_ROW_W-1:0] wrow;
    logic [`SFR_COL_W-1:0] wcol;
    logic [3:0] wcnt;
    logic [3:0] wlen;
    logic [3:0] widx;
    logic [`SFR_WBUF_DEPTH-1:0][`SFR_DW-1:0] wbuf;
    logic [1:0] fcnt;
    logic pvalid;
    sfr_pgm_pkt_t [1:0] q;
    logic lock_err;
  } sfr_state_t;
endpackage

// ==== src/sfr_top.sv ====
// synchronous flash read interface: command decode, read bursts, write buffer
// Operation
// - sample commands, address, data on rising edge
// - ACTIVE captures bank and row to open
// - bank is 4096 rows by 256 x16 columns
// - READ column starts burst, rest generated internally
// - read bursts 1/2/4/8/page, terminate ends early
// - write bursts collected in eight-word buffer
// - read latency one, two or three clocks
// - new READ column accepted every cycle during burst; WRITE ignored until buffer drains
// - read one bank while another programs
// - sixteen blocks, each lockable by hardware/software
// - program started by hardware or software sequence
// - clock gate low freezes reads and write capture, suspends burst; program drain keeps running
`timescale 1ns/100ps
`default_nettype none
`include "sfr_consts.svh"
module sfr_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cke_i,
  input wire sfr_pkg::sfr_pins_t pins_i,
  input wire logic [`SFR_DW-1:0] dq_i,
  output logic [`SFR_DW-1:0] dq_o,
  output logic dq_oe_n_o,
  input wire logic [`SFR_BANKS-1:0] bank_busy_i,
  input wire logic [`SFR_BLOCKS-1:0] hw_lock_i,
  input wire logic [`SFR_BLOCKS-1:0] sw_lock_i,
  output sfr_pkg::sfr_arr_req_t arr_req_o,
  input wire logic [`SFR_DW-1:0] arr_rdata_i,
  output logic pgm_valid_o,
  output sfr_pkg::sfr_pgm_pkt_t pgm_pkt_o,
  input wire logic pgm_ready_i,
  output logic wr_locked_o
);
  import sfr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  function automatic sfr_cmd_t decode(input sfr_pins_t p);
    sfr_cmd_t c;
    c = SFR_CMD_NOP;
    if (!p.cs_n)
    begin
      unique case ({p.ras_n, p.cas_n, p.we_n})
        3'h0: c = SFR_CMD_LMR;
        3'h3: c = SFR_CMD_ACT;
        3'h5: c = SFR_CMD_RD;
        3'h4: c = SFR_CMD_WR;
        3'h6: c = SFR_CMD_BST;
        3'h2: c = SFR_CMD_PRE;
        default: c = SFR_CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // column mask of the burst, all ones for a full page
  function automatic logic [`SFR_COL_W-1:0] burst_mask(input logic [2:0] bl);
    logic [`SFR_COL_W-1:0] m;
    m = 8'hff;
    unique case (bl)
      3'h0: m = 8'h00;
      3'h1: m = 8'h01;
      3'h2: m = 8'h03;
      3'h3: m = 8'h07;
      default: m = 8'hff;
    endcase
    return m;
  endfunction

  function automatic logic [`SFR_COL_W-1:0] next_col(input logic [`SFR_COL_W-1:0] start,
      input logic [`SFR_COL_W-1:0] cnt, input logic [2:0] bl, input logic bt);
    logic [`SFR_COL_W-1:0] m;
    logic [`SFR_COL_W-1:0] off;
    m = burst_mask(bl);
    off = (bt && bl != `SFR_BL_CODE_FULL) ? (start ^ cnt) : (start + cnt);
    return (start & ~m) | (off & m);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  logic [`SFR_BLOCKS-1:0] lock_vec;
  genvar g;
  generate
    for (g = 0; g < `SFR_BLOCKS; g = g + 1)
    begin : g_lock
      assign lock_vec[g] = hw_lock_i[g] | sw_lock_i[g];
    end
  endgenerate

  sfr_state_t s_reg;
  sfr_state_t s_next;
  sfr_cmd_t cmd;
  logic [1:0] ba;
  logic [`SFR_COL_W-1:0] col;
  logic [3:0] blk;
  logic act_go;
  logic rd_go;
  logic wr_free;
  logic wr_go;
  logic wr_lock;

  assign cmd = decode(pins_i);
  assign ba = pins_i.ba;
  assign col = pins_i.addr[`SFR_COL_W-1:0];
  assign blk = {ba, s_reg.row[ba][`SFR_BLK_ROW_MSB:`SFR_BLK_ROW_LSB]};
  assign act_go = cke_i && cmd == SFR_CMD_ACT && !bank_busy_i[ba];
  assign rd_go = cke_i && cmd == SFR_CMD_RD && s_reg.open[ba];
  assign wr_free = !s_reg.wact && !s_reg.wdrain;
  assign wr_lock = cke_i && cmd == SFR_CMD_WR && s_reg.open[ba] && wr_free && lock_vec[blk];
  assign wr_go = cke_i && cmd == SFR_CMD_WR && s_reg.open[ba] && wr_free && !lock_vec[blk];

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [`SFR_COL_W-1:0] c;
    logic [`SFR_COL_W-1:0] m;
    logic ov;
    logic [`SFR_DW-1:0] od;
    logic pop;
    logic push;
    logic [1:0] fc;
    sfr_pgm_pkt_t pk;
    c = '0;
    m = burst_mask(s_reg.bl);
    ov = 1'b0;
    od = s_reg.dq;
    fc = s_reg.fcnt;
    pk = '0;
    pop = 1'b0;
    push = 1'b0;
    s_next = s_reg;
    s_next.lock_err = 1'b0;
    if (cke_i)
    begin
      s_next.arr.rd = 1'b0;
      if (cmd == SFR_CMD_LMR)
      begin
        if (pins_i.addr[`SFR_MR_BL_MSB:`SFR_MR_BL_LSB] <= 3'h3
            || pins_i.addr[`SFR_MR_BL_MSB:`SFR_MR_BL_LSB] == `SFR_BL_CODE_FULL)
          s_next.bl = pins_i.addr[`SFR_MR_BL_MSB:`SFR_MR_BL_LSB];
        s_next.bt = pins_i.addr[`SFR_MR_BT_BIT];
        if (pins_i.addr[`SFR_MR_LAT_MSB:`SFR_MR_LAT_LSB] inside {3'h1, 3'h2, 3'h3})
          s_next.lat = pins_i.addr[`SFR_MR_LAT_LSB+1:`SFR_MR_LAT_LSB];
      end
      if (act_go)
      begin
        s_next.open[ba] = 1'b1;
        s_next.row[ba] = pins_i.addr;
      end
      if (cmd == SFR_CMD_PRE)
        s_next.open[ba] = 1'b0;
      // read burst address generation
      if (rd_go)
      begin
        s_next.rd_act = (m != 8'h00);
        s_next.rd_bank = ba;
        s_next.rd_start = col;
        s_next.rd_cnt = '0;
        s_next.arr = '{rd: 1'b1, bank: ba, row: s_reg.row[ba], col: col};
      end
      else if (cmd == SFR_CMD_BST || (cmd == SFR_CMD_PRE && ba == s_reg.rd_bank))
        s_next.rd_act = 1'b0;
      else if (s_reg.rd_act)
      begin
        c = s_reg.rd_cnt + 8'h01;
        s_next.rd_cnt = c;
        s_next.arr = '{rd: 1'b1, bank: s_reg.rd_bank, row: s_reg.row[s_reg.rd_bank],
                       col: next_col(s_reg.rd_start, c, s_reg.bl, s_reg.bt)};
        if (s_reg.bl != `SFR_BL_CODE_FULL && c == m)
          s_next.rd_act = 1'b0;
      end
      // latency pipeline
      s_next.vp = {s_reg.vp[1:0], s_next.arr.rd};
      s_next.d1 = arr_rdata_i;
      s_next.d2 = s_reg.d1;
      case (s_reg.lat)
        2'h1:
        begin
          ov = s_reg.vp[0];
          od = arr_rdata_i;
        end
        2'h2:
        begin
          ov = s_reg.vp[1];
          od = s_reg.d1;
        end
        default:
        begin
          ov = s_reg.vp[2];
          od = s_reg.d2;
        end
      endcase
      s_next.dq = ov ? od : s_reg.dq;
      s_next.dq_oe_n = !ov;
      // write burst capture
      if (wr_lock)
        s_next.lock_err = 1'b1;
      if (wr_go)
      begin
        s_next.wbuf[0] = dq_i;
        s_next.wcnt = 4'h1;
        s_next.wlen = (s_reg.bl == `SFR_BL_CODE_FULL) ? 4'h8 : 4'(m) + 4'h1;
        s_next.wact = (m != 8'h00);
        s_next.wdrain = (m == 8'h00);
        s_next.widx = '0;
        s_next.wbank = ba;
        s_next.wrow = s_reg.row[ba];
        s_next.wcol = col;
        s_next.wseq = pins_i.addr[`SFR_SEQ_SEL_BIT];
      end
      else if (s_reg.wact && cmd == SFR_CMD_BST)
      begin
        s_next.wact = 1'b0;
        s_next.wdrain = 1'b1;
        s_next.wlen = s_reg.wcnt;
      end
      else if (s_reg.wact)
      begin
        s_next.wbuf[s_reg.wcnt[2:0]] = dq_i;
        s_next.wcnt = s_reg.wcnt + 4'h1;
        if (s_reg.wcnt + 4'h1 == s_reg.wlen)
        begin
          s_next.wact = 1'b0;
          s_next.wdrain = 1'b1;
        end
      end
    end
    // drain into the two-entry buffer, runs even while clock gate is low
    pop = s_reg.pvalid && pgm_ready_i;
    push = s_reg.wdrain && (s_reg.fcnt != 2'h2 || pop);
    if (pop)
    begin
      s_next.q[0] = s_reg.q[1];
      fc = fc - 2'h1;
    end
    if (push)
    begin
      pk.sw_seq = !s_reg.wseq;
      pk.blk = {s_reg.wbank, s_reg.wrow[`SFR_BLK_ROW_MSB:`SFR_BLK_ROW_LSB]};
      pk.bank = s_reg.wbank;
      pk.row = s_reg.wrow;
      pk.col = s_reg.wcol + {4'h0, s_reg.widx};
      pk.data = s_reg.wbuf[s_reg.widx[2:0]];
      s_next.q[fc[0]] = pk;
      fc = fc + 2'h1;
      s_next.widx = s_reg.widx + 4'h1;
      if (s_reg.widx + 4'h1 == s_reg.wlen)
        s_next.wdrain = 1'b0;
    end
    s_next.fcnt = fc;
    s_next.pvalid = (fc != 2'h0);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_reg <= '0;
      s_reg.bl <= `SFR_BL_RST;
      s_reg.bt <= `SFR_BT_RST;
      s_reg.lat <= `SFR_LAT_RST;
      s_reg.dq_oe_n <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign dq_o = s_reg.dq;
  assign dq_oe_n_o = s_reg.dq_oe_n;
  assign arr_req_o = s_reg.arr;
  assign pgm_valid_o = s_reg.pvalid;
  assign pgm_pkt_o = s_reg.q[0];
  assign wr_locked_o = s_reg.lock_err;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_lat_one_data: assert property (
    (rd_go && s_reg.lat == 2'h1) ##1 cke_i |=> !dq_oe_n_o)
    else $error("latency one data late");
  a_lat_three_data: assert property (
    (rd_go && s_reg.lat == 2'h3) ##1 cke_i [*3] |=> !dq_oe_n_o)
    else $error("latency three data late");
  a_read_start_col: assert property (
    rd_go |=> arr_req_o.rd && arr_req_o.col == $past(col))
    else $error("burst start column wrong");
  a_act_row_open: assert property (
    act_go |=> s_reg.open[$past(ba)] && s_reg.row[$past(ba)] == $past(pins_i.addr))
    else $error("row not opened");
  a_busy_no_open: assert property (
    (cke_i && cmd == SFR_CMD_ACT && bank_busy_i[ba] && !s_reg.open[ba]) |=> !s_reg.open[$past(ba)])
    else $error("busy bank opened");
  a_oe_only_data: assert property (
    !dq_oe_n_o |-> $past(s_reg.vp) != 3'h0)
    else $error("data driven outside burst");
  a_bst_stops_read: assert property (
    (cke_i && cmd == SFR_CMD_BST) |=> !s_reg.rd_act)
    else $error("burst not terminated");
  a_cke_freeze: assert property (
    !cke_i |=> $stable(dq_o) && $stable(dq_oe_n_o) && $stable(s_reg.rd_cnt))
    else $error("state moved while gated");
  a_locked_refused: assert property (
    wr_lock |=> wr_locked_o && !s_reg.wact && !s_reg.wdrain)
    else $error("locked write accepted");
  a_wbuf_fill_len: assert property (
    (wr_go && s_reg.bl == 3'h3) ##1 (cke_i && cmd != SFR_CMD_BST) [*7] |=> s_reg.wdrain)
    else $error("write burst length wrong");
endmodule
`default_nettype wire

// ==== tb/sfr_far_end.sv ====
// far-end model: array read port and program engine
`timescale 1ns/100ps
`default_nettype none
`include "sfr_consts.svh"
module sfr_far_end (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire sfr_pkg::sfr_arr_req_t arr_req_i,
  output logic [`SFR_DW-1:0] rdata_o,
  input wire logic pgm_valid_i,
  input wire sfr_pkg::sfr_pgm_pkt_t pgm_pkt_i,
  output logic pgm_ready_o,
  input wire logic hold_i
);
  import sfr_pkg::*;
  sfr_pgm_pkt_t got[$];
  logic toggle;
  logic [15:0] junk;
  function automatic logic [15:0] word(logic [1:0] b, logic [11:0] r, logic [7:0] c);
    return {b, r[5:0], c};
  endfunction
  ////////////////////////////////
  // word in the cycle that the strobe stands, a changing pattern otherwise
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      junk <= 16'h5a5a;
    else
      junk <= ~junk;
  end
  assign rdata_o = arr_req_i.rd ? word(arr_req_i.bank, arr_req_i.row, arr_req_i.col)
    : junk;
  ////////////////////////////////
  // engine takes a word every other cycle, none while held
  always @(posedge clk_i)
  begin
    toggle <= reset_i ? 1'b0 : ~toggle;
    if (!reset_i && pgm_valid_i && pgm_ready_o)
      got.push_back(pgm_pkt_i);
  end
  assign pgm_ready_o = !hold_i && toggle;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the flash read interface
`timescale 1ns/100ps
`default_nettype none
`include "sfr_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb;
  import sfr_pkg::*;
  logic clk_i = 0, reset_i = 1, hold = 1, cke = 1;
  sfr_pins_t pins = '1;
  logic [15:0] dq_i = 0, dq_o, rdata, hw_lock = 0, sw_lock = 0;
  logic dq_oe_n_o, pgm_valid_o, pgm_ready, wr_locked_o;
  logic [3:0] busy = 0;
  sfr_arr_req_t arr_req;
  sfr_pgm_pkt_t pgm_pkt;
  int n_errors = 0, checked = 0, cycles = 0;
  always #25 clk_i = ~clk_i;
  sfr_top dut (.clk_i(clk_i), .reset_i(reset_i), .cke_i(cke), .pins_i(pins), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .bank_busy_i(busy), .hw_lock_i(hw_lock),
    .sw_lock_i(sw_lock), .arr_req_o(arr_req), .arr_rdata_i(rdata),
    .pgm_valid_o(pgm_valid_o), .pgm_pkt_o(pgm_pkt), .pgm_ready_i(pgm_ready),
    .wr_locked_o(wr_locked_o));
  sfr_far_end far (.clk_i(clk_i), .reset_i(reset_i), .arr_req_i(arr_req), .rdata_o(rdata),
    .pgm_valid_i(pgm_valid_o), .pgm_pkt_i(pgm_pkt), .pgm_ready_o(pgm_ready),
    .hold_i(hold));
  ////////////////////////////////
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      $display("ERROR %0t: timeout", $time);
      wrap_up();
    end
  end
  // entered and left at a falling edge, command left standing for the caller
  task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [11:0] a);
    pins = {1'b0, rcw, b, a};
    @(negedge clk_i);
  endtask
  task automatic mode(input logic [2:0] lat, input logic [2:0] bl, input logic bt);
    cmd(3'b000, 2'd0, {5'h0, lat, bt, bl});
  endtask
  task automatic read_chk(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c,
    input int lat, input int n, input logic il);
    logic [7:0] m, col;
    m = 8'(n - 1);
    cmd(3'b101, b, {4'h0, c});
    pins = '1;
    repeat (lat) @(negedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      col = il ? ((c & ~m) | ((c ^ 8'(i)) & m)) : ((c & ~m) | ((c + 8'(i)) & m));
      `CHK(dq_oe_n_o, 1'b0)
      `CHK(dq_o, far.word(b, r, col))
      @(negedge clk_i);
    end
    `CHK(dq_oe_n_o, 1'b1)
  endtask
  ////////////////////////////////
  task automatic t_reset();
    `CHK({dq_oe_n_o, pgm_valid_o, wr_locked_o, arr_req.rd}, 4'h8)
    $display("done: reset");
  endtask
  task automatic t_burst();
    int lt[4] = '{1, 2, 3, 2};
    cmd(3'b011, 2'd1, 12'h123);
    for (int k = 0; k < 4; k++)
    begin
      mode(3'(lt[k]), 3'(k), 1'(k));
      read_chk(2'd1, 12'h123, 8'h06, lt[k], 1 << k, 1'(k));
    end
    $display("done: burst");
  endtask
  task automatic t_term();
    int cnt = 0;
    mode(3'h1, 3'h7, 1'b0);
    pins = {1'b0, 3'b101, 2'd1, 12'h0fe};
    @(negedge clk_i);
    cmd(3'b110, 2'd0, 12'h000);
    pins = '1;
    `CHK(dq_o, far.word(2'd1, 12'h123, 8'hfe))
    repeat (8)
    begin
      cnt += dq_oe_n_o === 1'b0;
      @(negedge clk_i);
    end
    `CHK(cnt < 4, 1'b1)
    $display("done: terminate");
  endtask
  task automatic t_b2b();
    mode(3'h1, 3'h1, 1'b0);
    pins = {1'b0, 3'b101, 2'd1, 12'h010};
    @(negedge clk_i);
    pins = {1'b0, 3'b101, 2'd1, 12'h020};
    @(negedge clk_i);
    pins = '1;
    `CHK(dq_o, far.word(2'd1, 12'h123, 8'h10))
    @(negedge clk_i);
    `CHK(dq_o, far.word(2'd1, 12'h123, 8'h20))
    @(negedge clk_i);
    `CHK(dq_o, far.word(2'd1, 12'h123, 8'h21))
    $display("done: back to back");
  endtask
  task automatic t_write(input logic hw, input int n);
    sfr_pgm_pkt_t e;
    far.got.delete();
    hold = 1;
    for (int i = 0; i < n; i++)
    begin
      pins = i == 0 ? {1'b0, 3'b100, 2'd2, 1'b0, hw, 10'h030} : 18'h3ffff;
      dq_i = 16'ha500 + 16'(i);
      @(negedge clk_i);
    end
    repeat (10) @(negedge clk_i);
    `CHK(pgm_valid_o, 1'b1)
    `CHK(far.got.size(), 0)
    hold = 0;
    for (int i = 0; i < 40 && far.got.size() < n; i++) @(negedge clk_i);
    `CHK(far.got.size(), n)
    for (int i = 0; i < n; i++)
    begin
      e = '{sw_seq: !hw, blk: 4'ha, bank: 2'd2, row: 12'h823, col: 8'h30 + 8'(i),
        data: 16'ha500 + 16'(i)};
      `CHK(far.got[i], e)
    end
    $display("done: write");
  endtask
  task automatic t_lock();
    for (int k = 0; k < 2; k++)
    begin
      far.got.delete();
      hw_lock = k == 0 ? 16'h0400 : 16'h0;
      sw_lock = k == 1 ? 16'h0400 : 16'h0;
      cmd(3'b100, 2'd2, 12'h030);
      pins = '1;
      `CHK(wr_locked_o, 1'b1)
      @(negedge clk_i);
      `CHK(wr_locked_o, 1'b0)
      repeat (10) @(negedge clk_i);
      `CHK(far.got.size(), 0)
    end
    hw_lock = 0;
    sw_lock = 0;
    $display("done: lock");
  endtask
  task automatic t_busy();
    busy = 4'h8;
    cmd(3'b011, 2'd3, 12'h001);
    cmd(3'b101, 2'd3, 12'h000);
    pins = '1;
    repeat (5)
    begin
      `CHK(dq_oe_n_o, 1'b1)
      @(negedge clk_i);
    end
    read_chk(2'd1, 12'h123, 8'h00, 3, 8, 1'b0);
    busy = 0;
    cmd(3'b010, 2'd1, 12'h000);
    cmd(3'b101, 2'd1, 12'h000);
    pins = '1;
    repeat (5)
    begin
      @(negedge clk_i);
      `CHK(dq_oe_n_o, 1'b1)
    end
    $display("done: busy bank");
  endtask
  task automatic t_gate();
    mode(3'h1, 3'h2, 1'b0);
    cmd(3'b101, 2'd1, 12'h040);
    pins = '1;
    @(negedge clk_i);
    `CHK(dq_o, far.word(2'd1, 12'h123, 8'h40))
    cke = 0;
    repeat (3)
    begin
      @(negedge clk_i);
      `CHK({dq_oe_n_o, dq_o}, {1'b0, far.word(2'd1, 12'h123, 8'h40)})
    end
    cke = 1;
    for (int i = 1; i < 4; i++)
    begin
      @(negedge clk_i);
      `CHK(dq_o, far.word(2'd1, 12'h123, 8'h40 + 8'(i)))
    end
    @(negedge clk_i);
    `CHK(dq_oe_n_o, 1'b1)
    $display("done: clock gate");
  endtask
  ////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 0;
    t_reset();
    t_burst();
    t_term();
    t_b2b();
    t_gate();
    mode(3'h3, 3'h2, 1'b0);
    cmd(3'b011, 2'd2, 12'h823);
    t_write(1'b0, 4);
    mode(3'h3, 3'h3, 1'b0);
    t_write(1'b1, 8);
    t_lock();
    t_busy();
    wrap_up();
  end
endmodule
`default_nettype wire
